// File: bpb_pkg.sv
package bpb_pkg;
	// ***************************************************
	// Geometry
	// ***************************************************
	localparam int GROUPS       = 256;
	localparam int GROUP_BITS   = 8;
	localparam int ADDR_BITS    = 26;
	localparam int GROUP_LSB    = 18;
	localparam int SECTOR_KB    = 4;
	localparam int SECT_PER_GRP = 64;
	// ***************************************************
	// Reset and erased values
	// ***************************************************
	localparam logic PERSIST_ERASED = 1'h1;
	localparam logic PERSIST_PROG   = 1'h0;
	localparam logic VPB_UNPROT  = 1'h1;
	localparam logic LATCH_OPEN  = 1'h1;
	localparam logic LATCH_SHUT  = 1'h0;
	// ***************************************************
	// Timing
	// ***************************************************
	localparam int CLK_PERIOD_NS  = 10;
	localparam int PROG_TIME_US   = 200;
	localparam int ERASE_TIME_US  = 45000;
	localparam int PROG_CYCLES    = PROG_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int ERASE_CYCLES   = ERASE_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int PREP_CYCLES    = 16;
	localparam int CNT_BITS       = 24;
	// ***************************************************
	// Engine states
	// ***************************************************
	typedef enum logic [3:0] {
		BPB_IDLE  = 4'h1,
		BPB_PROG  = 4'h2,
		BPB_PREP  = 4'h4,
		BPB_ERASE = 4'h8
	} bpb_state_t;
endpackage

// File: bpb_timer.sv
`timescale 1ns/100ps
module bpb_timer #(
	parameter int WIDTH = 24
) (
	input  wire logic             clk_in,
	input  wire logic             reset_n_in,
	input  wire logic             load_in,
	input  wire logic [WIDTH-1:0] count_in,
	output logic                  done_out
);
	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;

	// ***************************************************
	// Down counter; done is a level while at zero
	// ***************************************************
	always_comb begin
		next_count = count;
		if (load_in) begin
			next_count = count_in;
		end else if (count != '0) begin
			next_count = count - WIDTH'(1);
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	// Done must not look at load: the engine reloads on done
	assign done_out = (count == '0);
endmodule

// File: bpb_protect.sv
`timescale 1ns/100ps
module bpb_protect #(
	parameter int GROUPS       = bpb_pkg::GROUPS,
	parameter int PROG_CYCLES  = bpb_pkg::PROG_CYCLES,
	parameter int ERASE_CYCLES = bpb_pkg::ERASE_CYCLES
) (
	input  wire logic                          clk_in,
	input  wire logic                          reset_n_in,
	input  wire logic                          sw_reset_in,
	input  wire logic                          password_mode_in,
	input  wire logic                          persist_prog_cmd_in,
	input  wire logic                          persist_erase_cmd_in,
	input  wire logic                          persistent_protect_read_cmd_in,
	input  wire logic                          volatile_protect_write_cmd_in,
	input  wire logic                          volatile_data_in,
	input  wire logic                          guard_latch_clear_cmd_in,
	input  wire logic                          password_unlock_ok_in,
	input  wire logic [bpb_pkg::ADDR_BITS-1:0] addr_in,
	input  wire logic                          array_read_req_in,
	input  wire logic [bpb_pkg::ADDR_BITS-1:0] check_addr_in,
	output logic                               busy_out,
	output logic                               prot_fail_out,
	output logic                               read_valid_out,
	output logic                               read_bit_out,
	output logic                               array_read_grant_out,
	output logic                               check_protected_out,
	output logic                               persistent_guard_latch_out
);
	localparam int GB = bpb_pkg::GROUP_BITS;

	// shipped erased; no reset may touch these
	logic [GROUPS-1:0]   persistent_protect_bit =
		{GROUPS{bpb_pkg::PERSIST_ERASED}};
	logic [GROUPS-1:0]   next_persistent_protect_bit;
	logic [GROUPS-1:0]   volatile_protect_bit;
	logic [GROUPS-1:0]   next_volatile_protect_bit;
	logic                persistent_guard_latch;
	logic                next_persistent_guard_latch;
	logic                factory_done;
	logic                next_factory_done;
	logic                idle;
	logic                latch_open;
	logic                prog_go;
	logic                erase_go;
	logic                cmd_refused;
	bpb_pkg::bpb_state_t state;
	bpb_pkg::bpb_state_t next_state;
	logic [GB-1:0]       target;
	logic [GB-1:0]       next_target;
	logic                prot_fail;
	logic                next_prot_fail;
	logic                read_valid;
	logic                next_read_valid;
	logic                read_bit;
	logic                next_read_bit;
	logic                timer_load;
	logic [bpb_pkg::CNT_BITS-1:0] timer_count;
	logic                timer_done;
	logic [GB-1:0]       cmd_group;
	logic [GB-1:0]       chk_group;

	// ***************************************************
	// Address to group mapping
	// ***************************************************
	// group from address
	assign cmd_group = addr_in[bpb_pkg::GROUP_LSB +: GB];
	assign chk_group = check_addr_in[bpb_pkg::GROUP_LSB +: GB];

	// ***************************************************
	// Busy timer
	// ***************************************************
	bpb_timer #(
		.WIDTH (bpb_pkg::CNT_BITS)
	) u_timer (
		.clk_in     (clk_in),
		.reset_n_in (reset_n_in),
		.load_in    (timer_load),
		.count_in   (timer_count),
		.done_out   (timer_done)
	);

	// ***************************************************
	// Command acceptance
	// ***************************************************
	assign idle        = (state == bpb_pkg::BPB_IDLE);
	assign latch_open  = (persistent_guard_latch == bpb_pkg::LATCH_OPEN);
	// Program wins when both strobes arrive together
	assign prog_go     = idle && persist_prog_cmd_in && latch_open;
	assign erase_go    = idle && !persist_prog_cmd_in &&
		persist_erase_cmd_in && latch_open;
	assign cmd_refused = idle && !latch_open &&
		(persist_prog_cmd_in || persist_erase_cmd_in);

	// ***************************************************
	// Program and erase engine
	// ***************************************************
	always_comb begin
		next_state  = state;
		next_target = target;
		timer_load  = 1'b0;
		timer_count = '0;
		case (state)
			bpb_pkg::BPB_IDLE: begin
				if (prog_go) begin
					next_target = cmd_group;
					timer_load  = 1'b1;
					timer_count = bpb_pkg::CNT_BITS'(PROG_CYCLES);
					next_state  = bpb_pkg::BPB_PROG;
				end else if (erase_go) begin
					timer_load  = 1'b1;
					timer_count = bpb_pkg::CNT_BITS'(bpb_pkg::PREP_CYCLES);
					next_state  = bpb_pkg::BPB_PREP;
				end
			end
			bpb_pkg::BPB_PROG: begin
				if (timer_done) begin
					next_state = bpb_pkg::BPB_IDLE;
				end
			end
			bpb_pkg::BPB_PREP: begin
				if (timer_done) begin
					timer_load  = 1'b1;
					timer_count = bpb_pkg::CNT_BITS'(ERASE_CYCLES);
					next_state  = bpb_pkg::BPB_ERASE;
				end
			end
			bpb_pkg::BPB_ERASE: begin
				if (timer_done) begin
					next_state = bpb_pkg::BPB_IDLE;
				end
			end
			default: begin
				next_state = bpb_pkg::BPB_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state  <= bpb_pkg::BPB_IDLE;
			target <= '0;
		end else begin
			state  <= next_state;
			target <= next_target;
		end
	end

	// ***************************************************
	// Refusal flag
	// ***************************************************
	always_comb begin
		next_prot_fail = prot_fail;
		if (cmd_refused) begin
			next_prot_fail = 1'b1;
		end else if (prog_go || erase_go) begin
			// Cleared only by a command that is carried out or by a hardware reset
			next_prot_fail = 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			prot_fail <= 1'b0;
		end else begin
			prot_fail <= next_prot_fail;
		end
	end

	// ***************************************************
	// Persistent bits
	// ***************************************************
	always_comb begin
		next_persistent_protect_bit = persistent_protect_bit;
		case (state)
			bpb_pkg::BPB_PROG: begin
				if (timer_done) begin
					next_persistent_protect_bit[target] =
						bpb_pkg::PERSIST_PROG;
				end
			end
			bpb_pkg::BPB_PREP: begin
				if (timer_done) begin
					next_persistent_protect_bit = '0;
				end
			end
			bpb_pkg::BPB_ERASE: begin
				if (timer_done) begin
					next_persistent_protect_bit = '1;
				end
			end
			default: begin
				next_persistent_protect_bit = persistent_protect_bit;
			end
		endcase
	end

	// non-volatile: a hardware reset keeps these bits
	always_ff @(posedge clk_in) begin
		persistent_protect_bit <= next_persistent_protect_bit;
	end

	// ***************************************************
	// Volatile bits
	// ***************************************************
	always_comb begin
		next_volatile_protect_bit = volatile_protect_bit;
		if (sw_reset_in) begin
			next_volatile_protect_bit = '1;
		end else if (volatile_protect_write_cmd_in) begin
			next_volatile_protect_bit[cmd_group] = volatile_data_in;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			volatile_protect_bit <= '1;
		end else begin
			volatile_protect_bit <= next_volatile_protect_bit;
		end
	end

	// ***************************************************
	// Mode strap sampling
	// ***************************************************
	// Mode strap is sampled on the first edge after release, since
	// an async reset may only load a constant.
	always_comb begin
		next_factory_done = 1'b1;
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			factory_done <= 1'b0;
		end else begin
			factory_done <= next_factory_done;
		end
	end

	// ***************************************************
	// Guard latch
	// ***************************************************
	always_comb begin
		next_persistent_guard_latch = persistent_guard_latch;
		if (!factory_done) begin
			next_persistent_guard_latch = password_mode_in ?
				bpb_pkg::LATCH_SHUT : bpb_pkg::LATCH_OPEN;
		end else if (guard_latch_clear_cmd_in) begin
			next_persistent_guard_latch = bpb_pkg::LATCH_SHUT;
		end else if (password_mode_in && password_unlock_ok_in) begin
			next_persistent_guard_latch = bpb_pkg::LATCH_OPEN;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			persistent_guard_latch <= bpb_pkg::LATCH_SHUT;
		end else begin
			persistent_guard_latch <= next_persistent_guard_latch;
		end
	end

	// ***************************************************
	// Persistent bit read
	// ***************************************************
	always_comb begin
		next_read_valid = 1'b0;
		next_read_bit   = read_bit;
		if (persistent_protect_read_cmd_in) begin
			next_read_valid = 1'b1;
			next_read_bit   = persistent_protect_bit[cmd_group];
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			read_valid <= 1'b0;
			read_bit   <= bpb_pkg::PERSIST_ERASED;
		end else begin
			read_valid <= next_read_valid;
			read_bit   <= next_read_bit;
		end
	end

	// ***************************************************
	// Protection check
	// ***************************************************
	// either bit protects
	assign check_protected_out =
		(persistent_protect_bit[chk_group] == bpb_pkg::PERSIST_PROG) ||
		(volatile_protect_bit[chk_group] != bpb_pkg::VPB_UNPROT);

	// ***************************************************
	// Outputs
	// ***************************************************
	// busy for status registers
	assign busy_out = (state != bpb_pkg::BPB_IDLE);
	assign array_read_grant_out = array_read_req_in &&
		(state == bpb_pkg::BPB_IDLE);
	assign prot_fail_out              = prot_fail;
	assign read_valid_out             = read_valid;
	assign read_bit_out               = read_bit;
	assign persistent_guard_latch_out = persistent_guard_latch;
endmodule

// File: bpb_host_model.sv
`timescale 1ns/100ps
module bpb_host_model (
	input  wire logic        clk_in,
	output logic             prog_out,
	output logic             erase_out,
	output logic             read_out,
	output logic             vwrite_out,
	output logic             vdata_out,
	output logic             clear_out,
	output logic             unlock_out,
	output logic             swrst_out,
	output logic [25:0]      addr_out
);
	// ****************************************
	// Command pulses, one per call
	// ****************************************
	logic [6:0] sel;
	initial begin
		sel = 7'h00;
		vdata_out = 1'h1;
		addr_out = 26'h0000000;
	end
	assign {swrst_out, unlock_out, clear_out, vwrite_out} = sel[6:3];
	assign {read_out, erase_out, prog_out} = sel[2:0];
	task automatic send(input int k, input logic [7:0] g, input logic d);
		@(negedge clk_in);
		addr_out = {g, 18'h00000};
		vdata_out = d;
		sel = 7'h01 << k;
		@(negedge clk_in);
		sel = 7'h00;
	endtask
endmodule

// File: bpb_protect_checker.sv
`timescale 1ns/100ps
module bpb_protect_checker #(
	parameter int PROG_CYCLES  = bpb_pkg::PROG_CYCLES,
	parameter int ERASE_CYCLES = bpb_pkg::ERASE_CYCLES
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic password_mode_in,
	input wire logic persist_prog_cmd_in,
	input wire logic persist_erase_cmd_in,
	input wire logic persistent_protect_read_cmd_in,
	input wire logic guard_latch_clear_cmd_in,
	input wire logic password_unlock_ok_in,
	input wire logic array_read_req_in,
	input wire logic busy_out,
	input wire logic prot_fail_out,
	input wire logic read_valid_out,
	input wire logic array_read_grant_out,
	input wire logic persistent_guard_latch_out
);
	// ****************************************
	// Busy length counter
	// ****************************************
	int run;
	int next_run;
	wire logic go = (persist_prog_cmd_in | persist_erase_cmd_in) & ~busy_out;
	wire logic lat = persistent_guard_latch_out;
	always_comb next_run = busy_out ? run + 1 : 0;
	always_ff @(posedge clk_in or negedge reset_n_in)
		if (!reset_n_in) run <= 0; else run <= next_run;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	property p_grant;
		array_read_grant_out == (array_read_req_in && !busy_out);
	endproperty
	property p_start;
		go && lat |=> busy_out && !prot_fail_out;
	endproperty
	property p_refuse;
		go && !lat |=> !busy_out && prot_fail_out;
	endproperty
	property p_len;
		$fell(busy_out) |-> (run == PROG_CYCLES + 1) ||
			(run == ERASE_CYCLES + bpb_pkg::PREP_CYCLES + 2);
	endproperty
	property p_rd;
		1'b1 |=> read_valid_out == $past(persistent_protect_read_cmd_in);
	endproperty
	property p_clear;
		$past(reset_n_in) && guard_latch_clear_cmd_in |=> !lat;
	endproperty
	property p_keep;
		$past(reset_n_in) && !lat
			&& !(password_mode_in && password_unlock_ok_in) |=> !lat;
	endproperty
	property p_unlock;
		$past(reset_n_in) && password_mode_in && password_unlock_ok_in
			&& !guard_latch_clear_cmd_in |=> lat;
	endproperty
	a_grant: assert property (p_grant) else $error("grant wrong");
	a_start: assert property (p_start) else $error("no start");
	a_refuse: assert property (p_refuse) else $error("no refuse");
	a_len: assert property (p_len) else $error("busy length");
	a_rd: assert property (p_rd) else $error("read valid");
	a_clear: assert property (p_clear) else $error("clear");
	a_keep: assert property (p_keep) else $error("latch set");
	a_unlock: assert property (p_unlock) else $error("unlock");
	c_prog: cover property (go && lat);
	c_refuse: cover property (go && !lat);
	c_unlock: cover property (password_mode_in && password_unlock_ok_in);
endmodule
bind bpb_protect bpb_protect_checker #(.PROG_CYCLES(PROG_CYCLES),
	.ERASE_CYCLES(ERASE_CYCLES)) u_chk (.clk_in(clk_in),
	.reset_n_in(reset_n_in), .password_mode_in(password_mode_in),
	.persist_prog_cmd_in(persist_prog_cmd_in),
	.persist_erase_cmd_in(persist_erase_cmd_in),
	.persistent_protect_read_cmd_in(persistent_protect_read_cmd_in),
	.guard_latch_clear_cmd_in(guard_latch_clear_cmd_in),
	.password_unlock_ok_in(password_unlock_ok_in),
	.array_read_req_in(array_read_req_in), .busy_out(busy_out),
	.prot_fail_out(prot_fail_out), .read_valid_out(read_valid_out),
	.array_read_grant_out(array_read_grant_out),
	.persistent_guard_latch_out(persistent_guard_latch_out));

// File: tb_block_protection_bits.sv
`timescale 1ns/100ps
`define CHK(a, e, m) begin checks_done++; if ((a) !== (e)) begin \
	n_errors++; $display("unexpected at %0t: %s", $time, m); end end
module tb_block_protection_bits;
	logic clk_in, reset_n_in, pw, sw, pg, er, rd, vw, vd, cl, un, req;
	logic busy, fail, rv, rbit, grant, prot, latch;
	logic [25:0] addr, ca;
	logic pbit [256];
	logic vpb [256];
	int n_errors = 0;
	int checks_done = 0;
	int g;
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	bpb_host_model host (.clk_in(clk_in), .prog_out(pg), .erase_out(er),
		.read_out(rd), .vwrite_out(vw), .vdata_out(vd), .clear_out(cl),
		.unlock_out(un), .swrst_out(sw), .addr_out(addr));
	// Short counts keep the run brief
	bpb_protect #(.PROG_CYCLES(20), .ERASE_CYCLES(40)) dut (
		.clk_in(clk_in), .reset_n_in(reset_n_in), .sw_reset_in(sw),
		.password_mode_in(pw), .persist_prog_cmd_in(pg),
		.persist_erase_cmd_in(er), .persistent_protect_read_cmd_in(rd),
		.volatile_protect_write_cmd_in(vw), .volatile_data_in(vd),
		.guard_latch_clear_cmd_in(cl), .password_unlock_ok_in(un),
		.addr_in(addr), .array_read_req_in(req), .check_addr_in(ca),
		.busy_out(busy), .prot_fail_out(fail), .read_valid_out(rv),
		.read_bit_out(rbit), .array_read_grant_out(grant),
		.check_protected_out(prot), .persistent_guard_latch_out(latch));
	function automatic logic exp_prot(int k);
		return !(pbit[k] && vpb[k]);
	endfunction
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic wait_idle();
		for (int n = 0; n < 200 && busy !== 1'b0; n++) @(negedge clk_in);
		`CHK(busy, 1'b0, "still busy")
	endtask
	task automatic rd_chk(int k);
		host.send(2, k[7:0], 1'b1);
		`CHK(rv, 1'b1, "read valid")
		`CHK(rbit, pbit[k], "bit value")
	endtask
	task automatic pr_chk(int k);
		// Last byte of the group must map to the same bits
		ca = {k[7:0], 18'h3FFFF};
		#1;
		`CHK(prot, exp_prot(k), "protect state")
	endtask
	task automatic hard_reset(logic pm);
		reset_n_in = 1'b0;
		pw = pm;
		for (int i = 0; i < 256; i++) vpb[i] = 1'b1;
		repeat (16) @(negedge clk_in);
		reset_n_in = 1'b1;
		@(negedge clk_in);
	endtask
	initial begin
		#50000;
		n_errors++;
		give_verdict();
	end
	initial begin
		void'($urandom(10619));
		req = 1'b1;
		ca = 26'h0000000;
		for (int i = 0; i < 256; i++) pbit[i] = 1'b1;
		hard_reset(1'b0);
		`CHK(latch, 1'b1, "latch open")
		for (int i = 0; i < 256; i += 17) rd_chk(i);
		$display("test reset done");
		repeat (40) begin
			g = $urandom_range(255);
			vpb[g] = 1'($urandom_range(1));
			host.send(3, g[7:0], vpb[g]);
			req = 1'($urandom_range(1));
			pr_chk(g);
			`CHK(grant, req, "grant idle")
		end
		req = 1'b1;
		$display("test volatile done");
		host.send(3, g[7:0], 1'b1);
		vpb[g] = 1'b1;
		host.send(0, g[7:0], 1'b1);
		`CHK(busy, 1'b1, "busy")
		`CHK(grant, 1'b0, "array read")
		host.send(0, g[7:0] ^ 8'h02, 1'b1);
		wait_idle();
		pbit[g] = 1'b0;
		`CHK(fail, 1'b0, "refused")
		rd_chk(g);
		rd_chk(g ^ 2);
		pr_chk(g);
		$display("test program done");
		host.send(1, 8'($urandom_range(255)), 1'b1);
		wait_idle();
		for (int i = 0; i < 256; i++) pbit[i] = 1'b1;
		`CHK(grant, 1'b1, "array read")
		rd_chk(g);
		host.send(0, 8'(g ^ 1), 1'b1);
		wait_idle();
		pbit[g ^ 1] = 1'b0;
		rd_chk(g ^ 1);
		$display("test erase done");
		host.send(3, g[7:0], 1'b0);
		host.send(6, 8'h00, 1'b1);
		for (int i = 0; i < 256; i++) vpb[i] = 1'b1;
		pr_chk(g);
		`CHK(latch, 1'b1, "latch kept")
		host.send(4, 8'h00, 1'b1);
		`CHK(latch, 1'b0, "latch clear")
		host.send(5, 8'h00, 1'b1);
		`CHK(latch, 1'b0, "latch stays")
		host.send(0, g[7:0], 1'b1);
		`CHK(fail, 1'b1, "prog refused")
		`CHK(busy, 1'b0, "not busy")
		rd_chk(g);
		host.send(1, 8'h00, 1'b1);
		`CHK(fail, 1'b1, "erase refused")
		$display("test latch done");
		host.send(3, g[7:0], 1'b0);
		hard_reset(1'b1);
		`CHK(latch, 1'b0, "latch shut")
		pr_chk(g);
		rd_chk(g ^ 1);
		host.send(5, 8'h00, 1'b1);
		`CHK(latch, 1'b1, "unlocked")
		$display("test password done");
		give_verdict();
	end
endmodule
